/* File: logic/oag_unit.sv */
/*
 Operand and address generation unit: picks the operand source, the register
 value, the effective offset, the segment and the condition outcome for one
 decoded instruction per request; results are registered one cycle later.
 Assumes a decoder drives requests synchronous to clk and a segmentation
 stage consumes the registered results.
*/
// Behaviour
// - operand source is immediate, register, memory or I/O port; explicit or implicit.
// - arithmetic accepts immediates except both divides; immediate is 32 bits max.
// - register operand chosen from 32/16/8-bit gprs, segment, flags, system registers.
// - quadword pair puts first-named register high, second-named register low.
// - branch decisions take condition codes from the flags register status bits.
// - memory operand address is a segment selector plus byte offset.
// - instruction fetches always use the code segment, no override.
// - push and pop always use the stack segment, no override.
// - string destinations always use the extra data segment, no override.
// - stack or frame pointer base defaults to stack segment, else data segment.
// - other data references default to the data segment.
// - override prefix replaces the default segment for data loads and stores.
// - explicit 16-bit selector comes from memory or from a 16-bit register.
// - far pointer gives offset from first doubleword, selector from next word.
// - effective address is displacement plus base plus scaled index.
// - scale factor 2, 4 or 8 multiplies only the index.
// - displacement, base, index are two's complement; scale is always positive.
// - stack pointer is never accepted as index.
// - components combine freely, each optional; scale only with an index.
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_unit (
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            req_valid,
    input  wire oag_pkg::oag_src_t               req_src,
    input  wire logic                            req_implicit,
    input  wire logic                            req_arith,
    input  wire logic                            req_divide,
    input  wire logic [`OAG_DW-1:0]              req_imm,
    input  wire oag_pkg::oag_rc_t                req_reg_class,
    input  wire logic [`OAG_IDX_W-1:0]           req_reg_idx,
    input  wire logic [`OAG_IDX_W-1:0]           req_pair_hi_idx,
    input  wire logic [`OAG_IDX_W-1:0]           req_pair_lo_idx,
    input  wire logic [3:0]                      req_cond,
    input  wire oag_pkg::oag_acc_t               req_access,
    input  wire logic                            req_ovr_valid,
    input  wire oag_pkg::oag_seg_t               req_ovr_seg,
    input  wire logic                            req_base_valid,
    input  wire logic [`OAG_IDX_W-1:0]           req_base_idx,
    input  wire logic                            req_index_valid,
    input  wire logic [`OAG_IDX_W-1:0]           req_index_idx,
    input  wire oag_pkg::oag_scale_t             req_scale,
    input  wire oag_pkg::oag_disp_t              req_disp_size,
    input  wire logic [`OAG_DW-1:0]              req_disp,
    input  wire logic                            req_sel_from_mem,
    input  wire logic [`OAG_SEL_W-1:0]           mem_sel_word,
    input  wire logic [47:0]                     mem_far_ptr,
    input  wire logic [`OAG_NGPR*`OAG_DW-1:0]    gpr_vals,
    input  wire logic [`OAG_NSEG*`OAG_SEL_W-1:0] seg_vals,
    input  wire logic [`OAG_DW-1:0]              flags_reg,
    input  wire logic [`OAG_DW-1:0]              sys_reg_val,
    output logic                                 out_valid,
    output oag_pkg::oag_src_t                    out_src,
    output logic                                 out_implicit,
    output logic [`OAG_DW-1:0]                   out_operand,
    output logic [2*`OAG_DW-1:0]                 out_quad,
    output logic                                 out_imm_reject,
    output logic                                 out_cond_true,
    output oag_pkg::oag_seg_t                    out_seg,
    output logic [`OAG_SEL_W-1:0]                out_seg_sel,
    output logic [`OAG_DW-1:0]                   out_ea,
    output logic                                 out_index_fault,
    output logic [`OAG_SEL_W-1:0]                out_explicit_sel,
    output logic [`OAG_DW-1:0]                   out_far_off,
    output logic [`OAG_SEL_W-1:0]                out_far_sel
);
    import oag_pkg::*;

    logic [`OAG_DW-1:0]    gpr32 [`OAG_NGPR];
    logic [`OAG_SEL_W-1:0] segv  [`OAG_NSEG];

    genvar g;
    generate
        for (g = 0; g < `OAG_NGPR; g++) begin : g_gpr
            assign gpr32[g] = gpr_vals[g*`OAG_DW +: `OAG_DW];
        end
        for (g = 0; g < `OAG_NSEG; g++) begin : g_seg
            assign segv[g] = seg_vals[g*`OAG_SEL_W +: `OAG_SEL_W];
        end
    endgenerate

    // register operand view by class
    function automatic logic [`OAG_DW-1:0] reg_view(input oag_rc_t rc,
                                                   input logic [`OAG_IDX_W-1:0] idx);
        logic [`OAG_DW-1:0] r;
        r = `OAG_ZERO32;
        case (rc)
            OAG_RC_GPR32: r = gpr32[idx];
            OAG_RC_GPR16: r = {16'h0000, gpr32[idx][15:0]};
            OAG_RC_GPR8: begin
                // low four codes name low bytes, high four the second bytes
                if (idx < `OAG_BYTE_HI_IDX)
                    r = {24'h00_0000, gpr32[idx][7:0]};
                else
                    r = {24'h00_0000, gpr32[idx - `OAG_BYTE_HI_IDX][15:8]};
            end
            OAG_RC_SEG:   r = (idx < 3'(`OAG_NSEG)) ? {16'h0000, segv[idx]} : `OAG_ZERO32;
            OAG_RC_FLAGS: r = flags_reg;
            OAG_RC_SYS:   r = sys_reg_val;
            default:      r = `OAG_ZERO32;
        endcase
        return r;
    endfunction

    // condition outcome from status flags
    function automatic logic cond_eval(input logic [3:0] cc, input logic [`OAG_DW-1:0] f);
        logic c;
        logic b;
        b = 1'b0;
        case (cc[3:1])
            3'h0: b = f[`OAG_OF_BIT];
            3'h1: b = f[`OAG_CF_BIT];
            3'h2: b = f[`OAG_ZF_BIT];
            3'h3: b = f[`OAG_CF_BIT] | f[`OAG_ZF_BIT];
            3'h4: b = f[`OAG_SF_BIT];
            3'h5: b = f[`OAG_PF_BIT];
            3'h6: b = f[`OAG_SF_BIT] ^ f[`OAG_OF_BIT];
            3'h7: b = (f[`OAG_SF_BIT] ^ f[`OAG_OF_BIT]) | f[`OAG_ZF_BIT];
            default: b = 1'b0;
        endcase
        c = b ^ cc[0];
        return c;
    endfunction

    // effective address pieces
    logic [`OAG_DW-1:0] disp_ext;
    logic [`OAG_DW-1:0] base_term;
    logic [`OAG_DW-1:0] index_term;
    logic               index_fault;
    logic [`OAG_DW-1:0] ea_next;
    oag_seg_t           seg_default;
    oag_seg_t           seg_next;

    always_comb begin
        case (req_disp_size)
            OAG_DISP_8:  disp_ext = {{24{req_disp[7]}}, req_disp[7:0]};
            OAG_DISP_16: disp_ext = {{16{req_disp[15]}}, req_disp[15:0]};
            OAG_DISP_32: disp_ext = req_disp;
            default:     disp_ext = `OAG_ZERO32;
        endcase
    end

    assign base_term   = req_base_valid ? gpr32[req_base_idx] : `OAG_ZERO32;
    // a stack pointer index is flagged and left out of the sum
    assign index_fault = req_index_valid && (req_index_idx == `OAG_SP_IDX);
    // scale shifts only the index and only when one is present
    assign index_term  = (req_index_valid && !index_fault) ?
                         (gpr32[req_index_idx] << req_scale) : `OAG_ZERO32;
    assign ea_next     = `OAG_DW'(disp_ext + base_term + index_term);

    always_comb begin
        // stack-relative base picks the stack segment
        if (req_base_valid && (req_base_idx == `OAG_SP_IDX || req_base_idx == `OAG_FP_IDX))
            seg_default = OAG_SEG_STACK;
        else
            seg_default = OAG_SEG_DATA;
        // override reaches data references only
        case (req_access)
            OAG_ACC_FETCH:   seg_next = OAG_SEG_CODE;
            OAG_ACC_STACK:   seg_next = OAG_SEG_STACK;
            OAG_ACC_STR_DST: seg_next = OAG_SEG_EXTRA;
            OAG_ACC_DATA:    seg_next = req_ovr_valid ? req_ovr_seg : seg_default;
            default:         seg_next = OAG_SEG_DATA;
        endcase
    end

    oag_state_t state_reg;

    // valid leaves a flop of its own rather than a state decode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= OAG_ST_IDLE;
            out_valid <= 1'b0;
        end else begin
            out_valid <= req_valid;
            case (state_reg)
                OAG_ST_IDLE: state_reg <= req_valid ? OAG_ST_DONE : OAG_ST_IDLE;
                OAG_ST_DONE: state_reg <= req_valid ? OAG_ST_DONE : OAG_ST_IDLE;
                default:     state_reg <= OAG_ST_IDLE;
            endcase
        end
    end

    // operand source, value and acceptance
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_src        <= OAG_SRC_IMM;
            out_implicit   <= 1'b0;
            out_operand    <= `OAG_ZERO32;
            out_quad       <= {2{`OAG_ZERO32}};
            out_imm_reject <= 1'b0;
            out_cond_true  <= 1'b0;
        end else if (req_valid) begin
            out_src      <= req_src;
            out_implicit <= req_implicit;
            case (req_src)
                OAG_SRC_IMM: out_operand <= req_imm;
                OAG_SRC_REG: out_operand <= reg_view(req_reg_class, req_reg_idx);
                default:     out_operand <= `OAG_ZERO32;
            endcase
            out_quad       <= {gpr32[req_pair_hi_idx], gpr32[req_pair_lo_idx]};
            // refusal is only flagged; the immediate still passes
            out_imm_reject <= (req_src == OAG_SRC_IMM) && req_arith && req_divide;
            out_cond_true  <= cond_eval(req_cond, flags_reg);
        end
    end

    // memory address: segment, selector and offset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_seg         <= OAG_SEG_DATA;
            out_seg_sel     <= 16'h0000;
            out_ea          <= `OAG_ZERO32;
            out_index_fault <= 1'b0;
        end else if (req_valid) begin
            out_seg         <= seg_next;
            out_seg_sel     <= segv[seg_next];
            out_ea          <= ea_next;
            out_index_fault <= index_fault;
        end
    end

    // explicit selectors and far pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_explicit_sel <= 16'h0000;
            out_far_off      <= `OAG_ZERO32;
            out_far_sel      <= 16'h0000;
        end else if (req_valid) begin
            out_explicit_sel <= req_sel_from_mem ? mem_sel_word :
                                gpr32[req_reg_idx][15:0];
            out_far_off      <= mem_far_ptr[`OAG_FAR_OFF_LSB +: `OAG_DW];
            out_far_sel      <= mem_far_ptr[`OAG_FAR_SEL_LSB +: `OAG_SEL_W];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_fetch_code_seg: assert property (req_valid && req_access == OAG_ACC_FETCH
        |=> out_valid && out_seg == OAG_SEG_CODE) else $error("fetch not in code segment");
    a_stack_seg_fixed: assert property (req_valid && req_access == OAG_ACC_STACK
        |=> out_seg == OAG_SEG_STACK) else $error("push/pop not in stack segment");
    a_strdst_extra: assert property (req_valid && req_access == OAG_ACC_STR_DST
        |=> out_seg == OAG_SEG_EXTRA) else $error("string dest not in extra segment");
    a_base_stack_default: assert property (req_valid && req_access == OAG_ACC_DATA
        && !req_ovr_valid && req_base_valid && req_base_idx == `OAG_FP_IDX
        |=> out_seg == OAG_SEG_STACK) else $error("frame base not in stack segment");
    a_data_default: assert property (req_valid && req_access == OAG_ACC_DATA
        && !req_ovr_valid && !req_base_valid |=> out_seg == OAG_SEG_DATA)
        else $error("plain data not in data segment");
    a_override_taken: assert property (req_valid && req_access == OAG_ACC_DATA
        && req_ovr_valid |=> out_seg == $past(req_ovr_seg)) else $error("override ignored");
    a_index_sp_fault: assert property (req_valid && req_index_valid
        && req_index_idx == `OAG_SP_IDX |=> out_index_fault) else $error("sp index accepted");
    a_ea_disp_only: assert property (req_valid && !req_base_valid && !req_index_valid
        && req_disp_size == OAG_DISP_8 |=> out_ea == {{24{$past(req_disp[7])}},
        $past(req_disp[7:0])}) else $error("disp8 not sign extended");
    a_div_imm_reject: assert property (req_valid && req_src == OAG_SRC_IMM
        && req_arith |=> out_imm_reject == $past(req_divide)) else $error("imm divide check");
    a_quad_pair_order: assert property (req_valid
        |=> out_quad[`OAG_DW-1:0] == $past(gpr32[req_pair_lo_idx]))
        else $error("quad low half wrong");
    a_far_split: assert property (req_valid
        |=> out_far_sel == $past(mem_far_ptr[47:32])) else $error("far selector wrong");
    a_valid_hold: assert property (!req_valid |=> !out_valid) else $error("stale valid");
    a_valid_pulse: assert property (req_valid |=> out_valid) else $error("missing valid");

    // operand path
    a_src_copied: assert property (req_valid
        |=> out_src == $past(req_src) && out_implicit == $past(req_implicit))
        else $error("operand source not copied");
    a_mem_operand_zero: assert property (req_valid && req_src == OAG_SRC_MEM
        |=> out_operand == `OAG_ZERO32) else $error("memory source left an operand");
    a_imm_operand: assert property (req_valid && req_src == OAG_SRC_IMM
        |=> out_operand == $past(req_imm)) else $error("immediate not passed");
    a_flags_operand: assert property (req_valid && req_src == OAG_SRC_REG
        && req_reg_class == OAG_RC_FLAGS |=> out_operand == $past(flags_reg))
        else $error("flags operand wrong");
    a_word_operand: assert property (req_valid && req_src == OAG_SRC_REG
        && req_reg_class == OAG_RC_GPR16
        |=> out_operand == {16'h0000, $past(gpr32[req_reg_idx][`OAG_SEL_W-1:0])})
        else $error("word operand wrong");
    a_quad_high_half: assert property (req_valid
        |=> out_quad[2*`OAG_DW-1:`OAG_DW] == $past(gpr32[req_pair_hi_idx]))
        else $error("quad high half wrong");
    a_cond_carry: assert property (req_valid && req_cond == 4'h2
        |=> out_cond_true == $past(flags_reg[`OAG_CF_BIT]))
        else $error("carry condition wrong");
    a_cond_not_zero: assert property (req_valid && req_cond == 4'h5
        |=> out_cond_true == !$past(flags_reg[`OAG_ZF_BIT]))
        else $error("not-zero condition wrong");

    // address path
    a_code_selector: assert property (req_valid && req_access == OAG_ACC_FETCH
        |=> out_seg_sel == $past(segv[OAG_SEG_CODE])) else $error("code selector wrong");
    a_sp_base_stack: assert property (req_valid && req_access == OAG_ACC_DATA
        && !req_ovr_valid && req_base_valid && req_base_idx == `OAG_SP_IDX
        |=> out_seg == OAG_SEG_STACK) else $error("stack pointer base not in stack segment");
    a_base_disp_sum: assert property (req_valid && req_base_valid
        && !req_index_valid && req_disp_size == OAG_DISP_32
        |=> out_ea == `OAG_DW'($past(gpr32[req_base_idx]) + $past(req_disp)))
        else $error("base plus displacement wrong");
    a_index_scaled: assert property (req_valid && req_index_valid && !req_base_valid
        && req_index_idx != `OAG_SP_IDX && req_disp_size == OAG_DISP_NONE
        |=> out_ea == `OAG_DW'($past(gpr32[req_index_idx]) << $past(req_scale)))
        else $error("index not scaled");
    a_sp_index_dropped: assert property (req_valid && req_index_valid
        && req_base_valid && req_index_idx == `OAG_SP_IDX && req_disp_size == OAG_DISP_NONE
        |=> out_ea == $past(gpr32[req_base_idx])) else $error("stack pointer index summed");
    a_empty_ea_zero: assert property (req_valid && !req_base_valid && !req_index_valid
        && req_disp_size == OAG_DISP_NONE |=> out_ea == `OAG_ZERO32)
        else $error("empty address not zero");
    a_sel_from_mem: assert property (req_valid && req_sel_from_mem
        |=> out_explicit_sel == $past(mem_sel_word)) else $error("memory selector wrong");
    a_far_offset: assert property (req_valid
        |=> out_far_off == $past(mem_far_ptr[`OAG_DW-1:0])) else $error("far offset wrong");

    c_override_use: cover property (req_valid && req_access == OAG_ACC_DATA && req_ovr_valid);
    c_full_ea: cover property (req_valid && req_base_valid && req_index_valid
        && req_scale == OAG_SCALE_8 && req_disp_size == OAG_DISP_32);
    c_back_to_back: cover property (req_valid [*3]);
    c_index_fault: cover property (out_index_fault);
    c_imm_reject: cover property (out_imm_reject);
endmodule

/* File: pkg/oag_params.svh */
/*
 Constants for operand and address generation: widths, register indices,
 flag bit positions and field positions. Assumes inclusion by bare name.
*/
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

`define OAG_DW          32
`define OAG_SEL_W       16
`define OAG_NGPR        8
`define OAG_NSEG        6
`define OAG_IDX_W       3
`define OAG_SP_IDX      3'h4
`define OAG_FP_IDX      3'h5
`define OAG_BYTE_HI_IDX 3'h4
`define OAG_FAR_OFF_LSB 0
`define OAG_FAR_SEL_LSB 32
`define OAG_CF_BIT      0
`define OAG_PF_BIT      2
`define OAG_ZF_BIT      6
`define OAG_SF_BIT      7
`define OAG_OF_BIT      11
`define OAG_ZERO32      32'h0000_0000

`endif

/* File: pkg/oag_pkg.sv */
/*
 Types for operand and address generation.
 Assumes oag_params.svh sits on the include path.
*/
package oag_pkg;
    typedef enum logic [1:0] {
        OAG_SRC_IMM = 2'h0, OAG_SRC_REG = 2'h1, OAG_SRC_MEM = 2'h2, OAG_SRC_IO = 2'h3
    } oag_src_t;

    typedef enum logic [2:0] {
        OAG_SEG_EXTRA = 3'h0, OAG_SEG_CODE = 3'h1, OAG_SEG_STACK = 3'h2,
        OAG_SEG_DATA = 3'h3, OAG_SEG_F = 3'h4, OAG_SEG_G = 3'h5
    } oag_seg_t;

    typedef enum logic [1:0] {
        OAG_ACC_FETCH = 2'h0, OAG_ACC_STACK = 2'h1, OAG_ACC_STR_DST = 2'h2,
        OAG_ACC_DATA = 2'h3
    } oag_acc_t;

    typedef enum logic [2:0] {
        OAG_RC_GPR32 = 3'h0, OAG_RC_GPR16 = 3'h1, OAG_RC_GPR8 = 3'h2,
        OAG_RC_SEG = 3'h3, OAG_RC_FLAGS = 3'h4, OAG_RC_SYS = 3'h5
    } oag_rc_t;

    typedef enum logic [1:0] {
        OAG_DISP_NONE = 2'h0, OAG_DISP_8 = 2'h1, OAG_DISP_16 = 2'h2, OAG_DISP_32 = 2'h3
    } oag_disp_t;

    // scale code n multiplies the index by 2**n
    typedef enum logic [1:0] {
        OAG_SCALE_1 = 2'h0, OAG_SCALE_2 = 2'h1, OAG_SCALE_4 = 2'h2, OAG_SCALE_8 = 2'h3
    } oag_scale_t;

    typedef enum logic [1:0] {
        OAG_ST_IDLE = 2'b01, OAG_ST_DONE = 2'b10
    } oag_state_t;
endpackage

/* File: dv/oag_far_model.sv */
/*
 Far-side model for oag_unit: register file, segment registers, system
 register and memory words as fixed patterns.
 Assumes the bench reads the same values to form its expectations.
*/
`timescale 1ns/1ps
`include "oag_params.svh"

module oag_far_model (
    output logic [`OAG_NGPR*`OAG_DW-1:0]    gpr_vals,
    output logic [`OAG_NSEG*`OAG_SEL_W-1:0] seg_vals,
    output logic [`OAG_DW-1:0]              sys_reg_val,
    output logic [`OAG_SEL_W-1:0]           mem_sel_word,
    output logic [47:0]                     mem_far_ptr
);
    always_comb begin
        for (int i = 0; i < `OAG_NGPR; i++) begin
            gpr_vals[i*32+:32] = 32'h1111_1111 * (i + 1);
        end
        // top register near the wrap point
        gpr_vals[7*32+:32] = 32'hFFFF_FFF0;
        for (int i = 0; i < `OAG_NSEG; i++) begin
            seg_vals[i*16+:16] = 16'hA000 | 16'(i);
        end
    end
    assign sys_reg_val  = 32'h5A5A_0F0F;
    assign mem_sel_word = 16'hBEEF;
    assign mem_far_ptr  = 48'h1234_89AB_CDEF;
endmodule

/* File: dv/tb_top.sv */
/*
 Self-checking bench for oag_unit, one task per scenario.
 Assumes oag_pkg is compiled first and oag_params.svh is on the include path.
*/
`timescale 1ns/1ps
`include "oag_params.svh"

module tb_top;
    import oag_pkg::*;
    logic        clk, reset, req_valid, req_implicit, req_arith, req_divide;
    logic        req_ovr_valid, req_base_valid, req_index_valid, req_sel_from_mem;
    logic [31:0] req_imm, req_disp, flags_reg, sys_reg_val;
    logic [3:0]  req_cond;
    logic [2:0]  req_reg_idx, req_pair_hi_idx, req_pair_lo_idx, req_base_idx, req_index_idx;
    oag_src_t    req_src, out_src;
    oag_rc_t     req_reg_class;
    oag_acc_t    req_access;
    oag_seg_t    req_ovr_seg, out_seg;
    oag_scale_t  req_scale;
    oag_disp_t   req_disp_size;
    logic [15:0] mem_sel_word, out_seg_sel, out_explicit_sel, out_far_sel;
    logic [47:0] mem_far_ptr;
    logic [255:0] gpr_vals;
    logic [95:0] seg_vals;
    logic        out_valid, out_implicit, out_imm_reject, out_cond_true, out_index_fault;
    logic [31:0] out_operand, out_ea, out_far_off;
    logic [63:0] out_quad;
    int          miscompares, samples_checked;

    oag_far_model i_far (.gpr_vals, .seg_vals, .sys_reg_val, .mem_sel_word, .mem_far_ptr);

    oag_unit i_dut (.clk, .reset, .req_valid, .req_src, .req_implicit, .req_arith,
        .req_divide, .req_imm, .req_reg_class, .req_reg_idx, .req_pair_hi_idx,
        .req_pair_lo_idx, .req_cond, .req_access, .req_ovr_valid, .req_ovr_seg,
        .req_base_valid, .req_base_idx, .req_index_valid, .req_index_idx, .req_scale,
        .req_disp_size, .req_disp, .req_sel_from_mem, .mem_sel_word, .mem_far_ptr,
        .gpr_vals, .seg_vals, .flags_reg, .sys_reg_val, .out_valid, .out_src,
        .out_implicit, .out_operand, .out_quad, .out_imm_reject, .out_cond_true,
        .out_seg, .out_seg_sel, .out_ea, .out_index_fault, .out_explicit_sel,
        .out_far_off, .out_far_sel);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] g(int i);
        return gpr_vals[i*32+:32];
    endfunction

    task automatic tally_and_finish;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic clr;
        {req_implicit, req_arith, req_divide, req_ovr_valid} = '0;
        {req_base_valid, req_index_valid, req_sel_from_mem} = '0;
        {req_imm, req_disp, req_cond, req_reg_idx} = '0;
        {req_pair_hi_idx, req_pair_lo_idx, req_base_idx, req_index_idx} = '0;
        req_src = OAG_SRC_IMM;
        req_reg_class = OAG_RC_GPR32;
        req_access = OAG_ACC_DATA;
        req_ovr_seg = OAG_SEG_DATA;
        req_scale = OAG_SCALE_1;
        req_disp_size = OAG_DISP_NONE;
    endtask

    // one request, answer expected exactly one cycle later
    task automatic issue;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        chk("out_valid", 1, out_valid);
    endtask

    task automatic t_src;
        for (int s = 0; s < 8; s++) begin
            clr();
            req_src = oag_src_t'(s[1:0]);
            req_implicit = s[0];
            req_imm = 32'hFFFF_FFFF;
            req_arith = 1'b1;
            req_divide = s[2];
            req_reg_idx = 3'h5;
            issue();
            chk("out_src", s[1:0], out_src);
            chk("out_implicit", s[0], out_implicit);
            chk("out_operand", s[1:0] == 0 ? 32'hFFFF_FFFF : s[1:0] == 1 ? g(5) : 0,
                out_operand);
            chk("out_imm_reject", s[1:0] == 0 && s[2], out_imm_reject);
        end
    endtask

    task automatic t_reg;
        logic [31:0] e[6];
        e = '{g(5), g(5) & 32'hFFFF, (g(1) >> 8) & 32'hFF, seg_vals[80+:16], 0, sys_reg_val};
        flags_reg = 32'h0000_08C5;
        e[4] = flags_reg;
        for (int c = 0; c < 6; c++) begin
            clr();
            req_src = OAG_SRC_REG;
            req_reg_class = oag_rc_t'(c[2:0]);
            req_reg_idx = 3'h5;
            issue();
            chk("out_operand", e[c], out_operand);
        end
    endtask

    task automatic t_seg;
        oag_seg_t ex[8] = '{OAG_SEG_CODE, OAG_SEG_STACK, OAG_SEG_EXTRA, OAG_SEG_F,
            OAG_SEG_STACK, OAG_SEG_STACK, OAG_SEG_DATA, OAG_SEG_DATA};
        for (int k = 0; k < 8; k++) begin
            clr();
            req_src = OAG_SRC_MEM;
            req_access = k < 4 ? oag_acc_t'(k[1:0]) : OAG_ACC_DATA;
            req_ovr_valid = k < 4;
            req_ovr_seg = OAG_SEG_F;
            req_base_valid = k != 7;
            req_base_idx = k == 4 ? 3'h4 : k == 6 ? 3'h3 : 3'h5;
            issue();
            chk("out_seg", ex[k], out_seg);
            chk("out_seg_sel", seg_vals[ex[k]*16+:16], out_seg_sel);
        end
    endtask

    task automatic t_ea;
        int bv[7] = '{1, 0, 1, 0, 1, 1, 0};
        int b[7] = '{1, 0, 7, 0, 1, 6, 0};
        int iv[7] = '{1, 1, 0, 0, 1, 1, 1};
        int x[7] = '{2, 3, 0, 0, 4, 7, 6};
        int sc[7] = '{3, 2, 3, 0, 1, 1, 3};
        int ds[7] = '{1, 2, 3, 1, 0, 1, 0};
        logic [31:0] d[7] = '{32'h1234_56FC, 32'h0000_8000, 32'h20, 32'hFFFF_FFFF, 0, 32'h80,
            0};
        logic [31:0] dx, e;
        for (int k = 0; k < 7; k++) begin
            clr();
            req_src = OAG_SRC_MEM;
            req_base_valid = bv[k][0];
            req_base_idx = b[k][2:0];
            req_index_valid = iv[k][0];
            req_index_idx = x[k][2:0];
            req_scale = oag_scale_t'(sc[k][1:0]);
            req_disp_size = oag_disp_t'(ds[k][1:0]);
            req_disp = d[k];
            dx = ds[k] == 1 ? {{24{d[k][7]}}, d[k][7:0]} : ds[k] == 2 ?
                {{16{d[k][15]}}, d[k][15:0]} : ds[k] == 3 ? d[k] : 0;
            e = dx + (bv[k] ? g(b[k]) : 0) + ((iv[k] && x[k] != 4) ? g(x[k]) << sc[k] : 0);
            issue();
            chk("out_ea", e, out_ea);
            chk("out_index_fault", iv[k] && x[k] == 4, out_index_fault);
        end
        @(posedge clk);
        #1;
        chk("out_valid_low", 0, out_valid);
        chk("out_ea_hold", e, out_ea);
    endtask

    task automatic t_misc;
        for (int m = 0; m < 2; m++) begin
            clr();
            req_src = OAG_SRC_MEM;
            req_pair_hi_idx = m ? 3'h0 : 3'h2;
            req_pair_lo_idx = m ? 3'h6 : 3'h0;
            req_sel_from_mem = m[0];
            req_reg_idx = 3'h3;
            issue();
            chk("out_quad", m ? {g(0), g(6)} : {g(2), g(0)}, out_quad);
            chk("out_explicit_sel", m ? mem_sel_word : g(3) & 32'hFFFF,
                out_explicit_sel);
            chk("out_far_off", mem_far_ptr[31:0], out_far_off);
            chk("out_far_sel", mem_far_ptr[47:32], out_far_sel);
        end
    endtask

    task automatic t_cond;
        logic [31:0] fl;
        logic r;
        // three flag sets so every condition is seen both true and false
        for (int c = 0; c < 48; c++) begin
            clr();
            fl = c < 16 ? 32'h0000_0001 : c < 32 ? 32'h0000_08C4 : 32'h0000_0080;
            flags_reg = fl;
            req_cond = c[3:0];
            case (c[3:1])
                0: r = fl[11];
                1: r = fl[0];
                2: r = fl[6];
                3: r = fl[0] | fl[6];
                4: r = fl[7];
                5: r = fl[2];
                6: r = fl[7] ^ fl[11];
                default: r = (fl[7] ^ fl[11]) | fl[6];
            endcase
            issue();
            chk("out_cond_true", r ^ c[0], out_cond_true);
        end
    endtask

    initial begin
        #200us;
        miscompares++;
        $display("[FAIL] watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        miscompares = 0;
        samples_checked = 0;
        reset = 1'b1;
        flags_reg = 32'h0;
        req_valid = 1'b0;
        clr();
        repeat (6) @(posedge clk);
        #1;
        chk("rst_valid", 0, out_valid);
        chk("rst_seg", OAG_SEG_DATA, out_seg);
        reset = 1'b0;
        t_src();
        t_reg();
        t_seg();
        t_ea();
        t_misc();
        t_cond();
        tally_and_finish();
    end
endmodule
